// ===== hdl/supervisor_pkg.sv
// constants, types and helpers shared by the transmitter supervisor
`default_nettype none
package supervisor_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_NS        = 10;
	localparam int TICK_MS       = 100;
	localparam int TICK_CYCLES   = TICK_MS * 1_000_000 / CLK_NS;
	localparam int HOLD_MIN      = 5;
	localparam int HOLD_TICKS    = HOLD_MIN * 60 * 1000 / TICK_MS;
	localparam int MODLOSS_S     = 10;
	localparam int MODLOSS_TICKS = MODLOSS_S * 1000 / TICK_MS;
	localparam int BLINK_MS      = 500;
	localparam int BLINK_TICKS   = BLINK_MS / TICK_MS;
	localparam logic [11:0] HOLD_LAST  = 12'(HOLD_TICKS - 1);
	localparam logic [6:0]  MOD_LIMIT  = 7'(MODLOSS_TICKS);
	localparam logic [2:0]  BLINK_LAST = 3'(BLINK_TICKS - 1);

	// ************************************************************
	// register map and reset values
	// ************************************************************
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_FWD_MIN  = 8'h04;
	localparam logic [7:0] A_REFL_MAX = 8'h08;
	localparam logic [7:0] A_WARN     = 8'h0C;
	localparam logic [7:0] A_STATUS   = 8'h10;
	localparam logic [7:0] A_INT_STAT = 8'h14;
	localparam logic [7:0] A_INT_EN   = 8'h18;
	localparam logic [7:0] A_INT_CLR  = 8'h1C;
	localparam int C_OPERATE = 0;
	localparam int C_AUTO_SB = 1;
	localparam int C_REMOTE  = 2;
	localparam logic [7:0] RST_FWD_MIN  = 8'h40;
	localparam logic [7:0] RST_REFL_MAX = 8'h20;
	localparam logic [7:0] RST_WARN     = 8'h40;
	localparam logic [7:0] PWR_FULL     = 8'hFF;
	localparam logic [8:0] MARGIN_DIV   = 9'h014;

	// event bits of the interrupt registers
	localparam int EV_FWD   = 0;
	localparam int EV_REFL  = 1;
	localparam int EV_MODSB = 2;
	localparam int EV_WARN  = 3;
	localparam int EV_W     = 4;

	// ************************************************************
	// pin synchroniser lanes
	// ************************************************************
	localparam int SYNC_W = 5;
	localparam int P_MODLOSS_N = 0;
	localparam int P_SRC_SEL   = 1;
	localparam int P_OVERRIDE  = 2;
	localparam int P_REM_OP    = 3;
	localparam int P_REM_SB    = 4;
	localparam logic [SYNC_W-1:0] SYNC_RST = 5'h01;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		ST_STBY  = 2'b00,
		ST_RUN   = 2'b01,
		ST_HOLD  = 2'b11,
		ST_MODSB = 2'b10
	} tx_state_t;

	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} sync_st_t;

	typedef struct packed {
		logic [23:0] cnt;
		logic        tick;
	} div_st_t;

	// threshold raised by five percent, one bit wider
	function automatic logic [8:0] thr_plus_margin(input logic [7:0] t);
		return {1'b0, t} + ({1'b0, t} / MARGIN_DIV);
	endfunction

endpackage
`default_nettype wire

// ===== hdl/pin_sync.sv
// two-stage synchroniser for the asynchronous panel and jumper pins
`default_nettype none
module pin_sync
	import supervisor_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [SYNC_W-1:0] pins,
	output logic      [SYNC_W-1:0] pins_sync
);

	sync_st_t st_ff;
	sync_st_t nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = pins;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= {SYNC_RST, SYNC_RST};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pins_sync = st_ff.s2;

endmodule
`default_nettype wire

// ===== hdl/tick_divider.sv
// prescaler giving one-cycle tick pulses for the supervision timers
`default_nettype none
module tick_divider
	import supervisor_pkg::*;
#(
	parameter int TICK_N = TICK_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      tick
);

	div_st_t st_ff;
	div_st_t nxt_st;

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.tick = 1'b0;
		if (st_ff.cnt == 24'(TICK_N - 1)) begin
			nxt_st.cnt  = 24'h000000;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 24'h000001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;

endmodule
`default_nettype wire

// ===== hdl/transmitter_fault_supervisor.sv
// transmitter supervisor: power faults, foldback, stand-by, relays, APB
`default_nettype none
// Contract
// - low forward power in operation turns the transmitter off with a fault for five minutes.
// - after that hold-off the transmitter is re-enabled and trips again if forward power is still low.
// - reflected power at or above its maximum starts a gradual reduction of forward power.
// - reflected power at or over the maximum plus five percent turns the transmitter off for five minutes.
// - after the reflected hold-off it re-enables and trips again if still over the maximum plus five percent.
// - foldback keeps lowering forward power until reflected power is below the maximum.
// - once reflected power is normal, forward power climbs back to full on its own.
// - with auto stand-by enabled, modulation loss lasting over ten seconds forces stand-by.
// - after such a stand-by, a transmitter in operate mode resumes as soon as modulation returns.
// - amplifier power below the warning level blinks the amber health indicator.
// - with remote control disabled, terminal-block and serial commands are ignored.
// - source select low: relays released, modulator path used, modulator indicator lit.
// - source select high: relays energised, receiver path used, modulator indicator dark.
// - the override jumper forces the internal modulator regardless of source select.
module transmitter_fault_supervisor
	import supervisor_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  fwd_power,
	input  wire logic [7:0]  refl_power,
	input  wire logic [7:0]  amp_power,
	input  wire logic        mod_loss_n,
	input  wire logic        source_select_input,
	input  wire logic        select_override_jumper,
	input  wire logic        remote_operate_in,
	input  wire logic        remote_standby_in,
	input  wire logic        serial_cmd_valid,
	input  wire logic        serial_cmd_operate,
	output logic             tx_enable,
	output logic [7:0]       power_level,
	output logic             fwd_fault,
	output logic             refl_fault,
	output logic             amber_blink,
	output logic             modulator_input_relay,
	output logic             receiver_input_relay,
	output logic             modulator_enable_indicator,
	output logic             irq
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		tx_state_t        state;
		logic             op_mode;
		logic             auto_sb;
		logic             remote_en;
		logic [7:0]       fwd_min;
		logic [7:0]       refl_max;
		logic [7:0]       warn_lvl;
		logic [11:0]      hold_cnt;
		logic [6:0]       mod_cnt;
		logic [2:0]       blink_cnt;
		logic [7:0]       pwr;
		logic             fault_fwd;
		logic             fault_refl;
		logic             warn_d;
		logic             amber;
		logic             sel;
		logic             ind;
		logic             tx_en;
		logic [EV_W-1:0]  int_stat;
		logic [EV_W-1:0]  int_en;
		logic             irq;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} sup_st_t;

	sup_st_t           s_ff;
	sup_st_t           nxt_s;
	logic [SYNC_W-1:0] pin_s;
	logic              tick;
	logic              mod_ok;
	logic              refl_big;
	logic              fwd_low;
	logic              warn;
	logic              rem_on;
	logic              rem_off;
	logic              wr_ok;
	logic              ctrl_wr;
	logic [EV_W-1:0]   evt;
	logic [EV_W-1:0]   clr;

	function automatic logic is_mapped(input logic [7:0] a);
		return a <= A_INT_CLR && a[1:0] == 2'b00;
	endfunction

	// ************************************************************
	// pins and time base
	// ************************************************************
	pin_sync u_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pins      ({remote_standby_in, remote_operate_in, select_override_jumper,
		             source_select_input, mod_loss_n}),
		.pins_sync (pin_s)
	);

	tick_divider #(
		.TICK_N (TICK_CYCLES_P)
	) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick)
	);

	assign mod_ok   = pin_s[P_MODLOSS_N];
	// trip at threshold plus five percent
	assign refl_big = {1'b0, refl_power} >= thr_plus_margin(s_ff.refl_max);
	assign fwd_low  = fwd_power < s_ff.fwd_min;
	assign warn     = amp_power < s_ff.warn_lvl;
	assign wr_ok    = psel && penable && s_ff.pready && pwrite;
	assign ctrl_wr  = wr_ok && paddr == A_CTRL;

	// remote commands gated by the enable
	assign rem_on  = s_ff.remote_en &&
	                 (pin_s[P_REM_OP] || (serial_cmd_valid && serial_cmd_operate));
	assign rem_off = s_ff.remote_en &&
	                 (pin_s[P_REM_SB] || (serial_cmd_valid && !serial_cmd_operate));

	always_comb begin
		nxt_s         = s_ff;
		evt           = '0;
		clr           = '0;

		// ************************************************************
		// APB slave: one wait state, error on unmapped words
		// ************************************************************
		nxt_s.pready  = 1'b0;
		nxt_s.pslverr = 1'b0;
		if (psel && penable && !s_ff.pready) begin
			nxt_s.pready  = 1'b1;
			nxt_s.pslverr = !is_mapped(paddr);
			nxt_s.prdata  = 32'h00000000;
			if (paddr == A_CTRL) begin
				nxt_s.prdata[2:0] = {s_ff.remote_en, s_ff.auto_sb, s_ff.op_mode};
			end else if (paddr == A_FWD_MIN) begin
				nxt_s.prdata[7:0] = s_ff.fwd_min;
			end else if (paddr == A_REFL_MAX) begin
				nxt_s.prdata[7:0] = s_ff.refl_max;
			end else if (paddr == A_WARN) begin
				nxt_s.prdata[7:0] = s_ff.warn_lvl;
			end else if (paddr == A_STATUS) begin
				nxt_s.prdata[15:0] = {s_ff.pwr, 1'b0, s_ff.tx_en, s_ff.sel,
				                      s_ff.amber, s_ff.fault_refl, s_ff.fault_fwd, s_ff.state};
			end else if (paddr == A_INT_STAT) begin
				nxt_s.prdata[EV_W-1:0] = s_ff.int_stat;
			end else if (paddr == A_INT_EN) begin
				nxt_s.prdata[EV_W-1:0] = s_ff.int_en;
			end
		end

		if (wr_ok && !s_ff.pslverr) begin
			if (paddr == A_CTRL) begin
				nxt_s.op_mode   = pwdata[C_OPERATE];
				nxt_s.auto_sb   = pwdata[C_AUTO_SB];
				nxt_s.remote_en = pwdata[C_REMOTE];
			end else if (paddr == A_FWD_MIN) begin
				nxt_s.fwd_min = pwdata[7:0];
			end else if (paddr == A_REFL_MAX) begin
				nxt_s.refl_max = pwdata[7:0];
			end else if (paddr == A_WARN) begin
				nxt_s.warn_lvl = pwdata[7:0];
			end else if (paddr == A_INT_EN) begin
				nxt_s.int_en = pwdata[EV_W-1:0];
			end else if (paddr == A_INT_CLR) begin
				clr = pwdata[EV_W-1:0];
			end
		end

		if (!ctrl_wr && rem_on) begin
			nxt_s.op_mode = 1'b1;
		end else if (!ctrl_wr && rem_off) begin
			nxt_s.op_mode = 1'b0;
		end

		// ************************************************************
		// modulation loss timer
		// ************************************************************
		// restart whenever loss begins anew
		if (mod_ok || !s_ff.auto_sb) begin
			nxt_s.mod_cnt = 7'h00;
		end else if (tick && s_ff.mod_cnt <= MOD_LIMIT) begin
			nxt_s.mod_cnt = s_ff.mod_cnt + 7'h01;
		end

		// ************************************************************
		// supervision state machine
		// ************************************************************
		case (s_ff.state)
			ST_STBY: begin
				nxt_s.pwr = PWR_FULL;
				if (s_ff.op_mode) begin
					nxt_s.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!s_ff.op_mode) begin
					nxt_s.state = ST_STBY;
				end else if (refl_big) begin
					nxt_s.state      = ST_HOLD;
					nxt_s.fault_refl = 1'b1;
					nxt_s.hold_cnt   = 12'h000;
					evt[EV_REFL]     = 1'b1;
				end else if (fwd_low) begin
					nxt_s.state     = ST_HOLD;
					nxt_s.fault_fwd = 1'b1;
					nxt_s.hold_cnt  = 12'h000;
					evt[EV_FWD]     = 1'b1;
				end else if (s_ff.mod_cnt > MOD_LIMIT) begin
					nxt_s.state    = ST_MODSB;
					evt[EV_MODSB]  = 1'b1;
				end else if (tick) begin
					// one small step per tick, never a cut
					if (refl_power >= s_ff.refl_max) begin
						// keep folding while not yet below
						if (s_ff.pwr != 8'h00) begin
							nxt_s.pwr = s_ff.pwr - 8'h01;
						end
					end else if (s_ff.pwr != PWR_FULL) begin
						nxt_s.pwr = s_ff.pwr + 8'h01;
					end
				end
			end
			ST_HOLD: begin
				if (!s_ff.op_mode) begin
					nxt_s.state      = ST_STBY;
					nxt_s.fault_fwd  = 1'b0;
					nxt_s.fault_refl = 1'b0;
				end else if (tick) begin
					if (s_ff.hold_cnt == HOLD_LAST) begin
						nxt_s.state      = ST_RUN;
						nxt_s.fault_fwd  = 1'b0;
						nxt_s.fault_refl = 1'b0;
					end else begin
						nxt_s.hold_cnt = s_ff.hold_cnt + 12'h001;
					end
				end
			end
			ST_MODSB: begin
				// resume as soon as modulation is back
				if (!s_ff.op_mode) begin
					nxt_s.state = ST_STBY;
				end else if (mod_ok) begin
					nxt_s.state = ST_RUN;
				end
			end
			default: begin
				nxt_s.state = ST_STBY;
			end
		endcase
		nxt_s.tx_en = nxt_s.state == ST_RUN;

		// ************************************************************
		// amber warning blink
		// ************************************************************
		// blink while amplifier output is low
		nxt_s.warn_d = warn;
		if (!warn) begin
			nxt_s.amber     = 1'b0;
			nxt_s.blink_cnt = 3'h0;
		end else if (tick) begin
			if (s_ff.blink_cnt == BLINK_LAST) begin
				nxt_s.blink_cnt = 3'h0;
				nxt_s.amber     = !s_ff.amber;
			end else begin
				nxt_s.blink_cnt = s_ff.blink_cnt + 3'h1;
			end
		end
		evt[EV_WARN] = warn && !s_ff.warn_d;

		// ************************************************************
		// IF source relays
		// ************************************************************
		// jumper forces the internal modulator
		nxt_s.sel = pin_s[P_SRC_SEL] && !pin_s[P_OVERRIDE];
		nxt_s.ind = !nxt_s.sel;

		// ************************************************************
		// interrupt status: a new event beats a clear
		// ************************************************************
		nxt_s.int_stat = (s_ff.int_stat & ~clr) | evt;
		nxt_s.irq      = |(nxt_s.int_stat & nxt_s.int_en);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff          <= '0;
			s_ff.state    <= ST_STBY;
			s_ff.fwd_min  <= RST_FWD_MIN;
			s_ff.refl_max <= RST_REFL_MAX;
			s_ff.warn_lvl <= RST_WARN;
			s_ff.pwr      <= PWR_FULL;
			s_ff.ind      <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata                     = s_ff.prdata;
	assign pready                     = s_ff.pready;
	assign pslverr                    = s_ff.pslverr;
	assign tx_enable                  = s_ff.tx_en;
	assign power_level                = s_ff.pwr;
	assign fwd_fault                  = s_ff.fault_fwd;
	assign refl_fault                 = s_ff.fault_refl;
	assign amber_blink                = s_ff.amber;
	assign modulator_input_relay      = s_ff.sel;
	assign receiver_input_relay       = s_ff.sel;
	assign modulator_enable_indicator = s_ff.ind;
	assign irq                        = s_ff.irq;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_fwd_trip: assert property (
		s_ff.state == ST_RUN && s_ff.op_mode && !refl_big && fwd_low
		|=> s_ff.state == ST_HOLD && fwd_fault && !tx_enable)
		else $error("forward power fault did not trip");

	a_hold_dark: assert property (
		s_ff.state == ST_HOLD |-> !tx_enable && (fwd_fault || refl_fault))
		else $error("transmitter on during hold-off");

	a_hold_release: assert property (
		s_ff.state == ST_HOLD && s_ff.op_mode && tick && s_ff.hold_cnt == HOLD_LAST
		|=> s_ff.state == ST_RUN && tx_enable && !fwd_fault)
		else $error("hold-off did not release");

	a_refl_trip: assert property (
		s_ff.state == ST_RUN && s_ff.op_mode && refl_big
		|=> s_ff.state == ST_HOLD && refl_fault && s_ff.hold_cnt == 12'h000)
		else $error("reflected trip missing");

	a_fold_down: assert property (
		s_ff.state == ST_RUN && nxt_s.state == ST_RUN && tick
		&& refl_power >= s_ff.refl_max && power_level != 8'h00
		|=> power_level == $past(power_level) - 8'h01)
		else $error("foldback step missing");

	a_fold_up: assert property (
		s_ff.state == ST_RUN && nxt_s.state == ST_RUN && tick
		&& refl_power < s_ff.refl_max && power_level != PWR_FULL
		|=> power_level == $past(power_level) + 8'h01)
		else $error("power recovery step missing");

	a_modsb_cause: assert property (
		s_ff.state != ST_MODSB ##1 s_ff.state == ST_MODSB
		|-> $past(s_ff.mod_cnt) > MOD_LIMIT && $past(s_ff.auto_sb))
		else $error("stand-by without sustained loss");

	a_modsb_exit: assert property (
		s_ff.state == ST_MODSB && s_ff.op_mode && mod_ok |=> tx_enable)
		else $error("no return after modulation restored");

	a_amber_off: assert property (
		!warn |=> !amber_blink)
		else $error("amber blinking without warning");

	a_remote_gate: assert property (
		!s_ff.remote_en && !ctrl_wr |=> s_ff.op_mode == $past(s_ff.op_mode))
		else $error("remote command obeyed while disabled");

	a_relay_pair: assert property (
		modulator_input_relay == receiver_input_relay
		&& modulator_enable_indicator == !modulator_input_relay)
		else $error("relays and indicator disagree");

	a_override: assert property (
		select_override_jumper [*3] |=> !modulator_input_relay && modulator_enable_indicator)
		else $error("override jumper not forcing modulator");

endmodule
`default_nettype wire

// ===== bench/rf_partner.sv
// behavioural detectors and IF processor facing the supervisor
`default_nettype none
module rf_partner (
	input  wire logic       tx_enable,
	input  wire logic [7:0] power_level,
	input  wire logic [7:0] fwd_set,
	input  wire logic [7:0] refl_set,
	input  wire logic [7:0] amp_set,
	input  wire logic       mod_ok,
	output logic      [7:0] fwd_power,
	output logic      [7:0] refl_power,
	output logic      [7:0] amp_power,
	output logic            mod_loss_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// forward and reflected detectors read zero with the carrier off
	assign fwd_power  = tx_enable ? fwd_set : 8'h00;
	// reflection scales with drive, otherwise foldback could never settle
	assign refl_power = tx_enable ? 8'((16'(refl_set) * 16'(power_level)) / 16'h00FF) : 8'h00;
	assign amp_power  = amp_set;
	assign mod_loss_n = mod_ok;
endmodule
`default_nettype wire

// ===== bench/tb_transmitter_fault_supervisor.sv
// self-checking bench for the transmitter supervisor
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; $display("ERROR %0t got %0h exp %0h", $time, a, e); end end
module tb_transmitter_fault_supervisor;
	import supervisor_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// signals and helpers
	// ****************************************
	localparam int TK = 4;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
	logic [7:0]  paddr, fwd_power, refl_power, amp_power, power_level;
	logic [31:0] pwdata, prdata, rd_v;
	logic        mod_loss_n, source_select_input, select_override_jumper, remote_operate_in, remote_standby_in;
	logic        serial_cmd_valid, serial_cmd_operate, tx_enable, fwd_fault, refl_fault, amber_blink, irq;
	logic        modulator_input_relay, receiver_input_relay, modulator_enable_indicator, mod_ok;
	logic [7:0]  fwd_set, refl_set, amp_set;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          cyc = 0;

	transmitter_fault_supervisor #(.TICK_CYCLES_P(TK)) u_transmitter_fault_supervisor (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fwd_power(fwd_power), .refl_power(refl_power),
		.amp_power(amp_power), .mod_loss_n(mod_loss_n), .source_select_input(source_select_input),
		.select_override_jumper(select_override_jumper), .remote_operate_in(remote_operate_in),
		.remote_standby_in(remote_standby_in), .serial_cmd_valid(serial_cmd_valid),
		.serial_cmd_operate(serial_cmd_operate), .tx_enable(tx_enable), .power_level(power_level),
		.fwd_fault(fwd_fault), .refl_fault(refl_fault), .amber_blink(amber_blink),
		.modulator_input_relay(modulator_input_relay), .receiver_input_relay(receiver_input_relay),
		.modulator_enable_indicator(modulator_enable_indicator), .irq(irq));
	rf_partner u_rf_partner (.tx_enable(tx_enable), .power_level(power_level), .fwd_set(fwd_set),
		.refl_set(refl_set), .amp_set(amp_set), .mod_ok(mod_ok), .fwd_power(fwd_power),
		.refl_power(refl_power), .amp_power(amp_power), .mod_loss_n(mod_loss_n));

	task automatic finish_test();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// pready is read just after the edge, before the slave's own update lands, so it is the sampled level
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_v = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd_v, e)
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return tx_enable;
			1: return fwd_fault;
			2: return refl_fault;
			default: return amber_blink;
		endcase
	endfunction

	task automatic wait_sig(input int s, input logic v, input int max, output int n);
		n = 0;
		#1;
		while (sig(s) !== v && n < max) begin
			@(posedge pclk);
			#1;
			n++;
		end
		`CHK(sig(s), v)
	endtask

	task automatic hold_retrip(input int f);
		int n;
		wait_sig(0, 1'b1, 12100, n);
		`CHK(n >= 2990 * TK && n <= 3010 * TK, 1'b1)
		wait_sig(f, 1'b1, 4, n);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		rdchk(A_CTRL, 32'h0);
		rdchk(A_FWD_MIN, 32'h40);
		rdchk(A_REFL_MAX, 32'h20);
		rdchk(A_WARN, 32'h40);
		rdchk(8'h20, 32'h0);
		`CHK(last_err, 1'b1)
	endtask

	task automatic t_relays();
		logic [1:0] cfg [3] = '{2'b00, 2'b01, 2'b11};
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			{select_override_jumper, source_select_input} <= cfg[i];
			idle(5);
			`CHK({modulator_input_relay, receiver_input_relay, modulator_enable_indicator}, (i == 1) ? 3'b110 : 3'b001)
		end
	endtask

	task automatic t_fwd();
		int n;
		wr(A_INT_EN, 32'hF);
		wr(A_CTRL, 32'h1);
		wait_sig(0, 1'b1, 8, n);
		`CHK(power_level, PWR_FULL)
		@(posedge pclk);
		fwd_set <= 8'h30;
		wait_sig(1, 1'b1, 4, n);
		`CHK({tx_enable, irq}, 2'b01)
		hold_retrip(1);
		rdchk(A_INT_STAT, 32'h1);
		wr(A_INT_CLR, 32'h1);
		idle(2);
		`CHK(irq, 1'b0)
		wr(A_CTRL, 32'h0);
		@(posedge pclk);
		fwd_set <= 8'h80;
	endtask

	task automatic t_refl();
		int n;
		wr(A_REFL_MAX, 32'h64);
		wr(A_CTRL, 32'h1);
		wait_sig(0, 1'b1, 8, n);
		@(posedge pclk);
		refl_set <= 8'h66;
		idle(20 * TK);
		`CHK(tx_enable && !refl_fault && (power_level inside {8'hF9, 8'hFA}), 1'b1)
		@(posedge pclk);
		refl_set <= 8'h00;
		idle(10 * TK);
		`CHK(power_level, PWR_FULL)
		@(posedge pclk);
		refl_set <= 8'hFF;
		wait_sig(2, 1'b1, 4, n);
		`CHK(tx_enable, 1'b0)
		hold_retrip(2);
		wr(A_CTRL, 32'h0);
		@(posedge pclk);
		refl_set <= 8'h00;
	endtask

	task automatic t_mod();
		int n;
		wr(A_CTRL, 32'h3);
		wait_sig(0, 1'b1, 8, n);
		@(posedge pclk);
		mod_ok <= 1'b0;
		idle(100 * TK - 4);
		`CHK(tx_enable, 1'b1)
		wait_sig(0, 1'b0, 20, n);
		rdchk(A_INT_STAT, 32'h6);
		@(posedge pclk);
		mod_ok <= 1'b1;
		wait_sig(0, 1'b1, 5, n);
	endtask

	task automatic t_amber();
		int n;
		wr(A_INT_EN, 32'h0);
		wr(A_INT_CLR, 32'hF);
		@(posedge pclk);
		amp_set <= 8'h30;
		wait_sig(3, 1'b1, 30, n);
		wait_sig(3, 1'b0, 30, n);
		`CHK(n >= 19 && n <= 21, 1'b1)
		rdchk(A_INT_STAT, 32'h8);
		`CHK(irq, 1'b0)
		wr(A_INT_EN, 32'h8);
		idle(2);
		`CHK(irq, 1'b1)
		wr(A_INT_CLR, 32'h8);
		idle(2);
		`CHK(irq, 1'b0)
		@(posedge pclk);
		amp_set <= 8'h80;
		wait_sig(3, 1'b0, 3, n);
	endtask

	task automatic t_remote();
		int n;
		wr(A_CTRL, 32'h1);
		@(posedge pclk);
		remote_standby_in <= 1'b1;
		serial_cmd_valid <= 1'b1;
		@(posedge pclk);
		serial_cmd_valid <= 1'b0;
		idle(8);
		`CHK(tx_enable, 1'b1)
		wr(A_CTRL, 32'h5);
		wait_sig(0, 1'b0, 8, n);
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// the longest path is two five-minute holds of scaled ticks
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			$display("ERROR %0t timeout", $time);
			finish_test();
		end
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{source_select_input, select_override_jumper, remote_operate_in, remote_standby_in} = '0;
		{serial_cmd_valid, serial_cmd_operate} = '0;
		{fwd_set, refl_set, amp_set, mod_ok} = {8'h80, 8'h00, 8'h80, 1'b1};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_relays();
		t_fwd();
		t_refl();
		t_mod();
		t_amber();
		t_remote();
		finish_test();
	end
endmodule
`undef CHK
`default_nettype wire
